//--- lrf_framer.sv
/*
 * lrf_framer: receive-entry formatter, transmit header builder and
 * sticky event flags, with an AXI4-Lite register slave.
 * Assumes the modem delivers header, payload and CRC bytes in air order
 * and that a queue manager reports free space and accepts the entry stream.
 */
// What this block does
// - each event line is gated by its own enable bit; disabled ones stay quiet.
// - raise event 0 on command done, event 1 on last chained command done.
// - raise event 4 on transmit, 5 on acknowledgment, 9 on retransmission.
// - control packets: event 6 sent, 7 acked, 8 ack acknowledged.
// - event 10 on transmit entry finished, 11 on buffer swap done.
// - receive: event 16 good payload, 17 crc failure, 18 ignorable.
// - event 19 for good, non-ignored packet without payload bytes.
// - event 20 for good control packet, 21 when it was also acknowledged.
// - event 22 when a packet does not fit and a length field is on, 23 when entry finishes.
// - events 29 modules opened, 30 boot done, 31 internal error.
// - received packets go to queue; connected sends from queue, others buffer.
// - optional zero, one or two byte length field from air length plus extras.
// - keep_length_byte keeps both header bytes, else only the first.
// - three crc bytes stored only when keep_crc is set.
// - signal strength byte appended when append_signal_strength is set.
// - status byte appended when append_status is set.
// - timestamp of packet start appended last, byte by byte, unaligned.
// - entry order: length, header, payload, crc, strength, status, timestamp.
// - connected header takes llid from first entry byte, length from entry.
// - connected header gets nesn, sn, md inserted and reserved bits zero.
// - advertising header built here; data length zero skips the buffer.
// - any data length accepted for every advertising message type.
// - config bits 4 crc, 5 strength, 6 status, 7 timestamp.
// - status byte: channel bits 0-5 or 0x3f, ignore bit 6, crc error bit 7.
`timescale 1ns/100ps
module lrf_framer
	import lrf_pkg::*;
#(
	parameter int TS_W = 32
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire lrf_seq_evt_t        seq_evt,
	output logic [31:0]              evt_lines,
	input  wire logic                rx_start,
	input  wire logic [TS_W-1:0]     rx_timestamp,
	input  wire logic [7:0]          rx_in_data,
	input  wire logic                rx_in_valid,
	output logic                     rx_in_ready,
	input  wire lrf_rx_meta_t        rx_meta,
	input  wire logic [7:0]          rxq_space,
	output logic [7:0]               rx_out_data,
	output logic                     rx_out_valid,
	output logic                     rx_out_last,
	input  wire logic                rx_out_ready,
	input  wire lrf_tx_req_t         tx_req,
	input  wire logic                tx_req_valid,
	output lrf_tx_hdr_t              tx_hdr,
	output logic                     tx_hdr_valid
);
	logic [31:0]   evt_flags;
	logic [31:0]   evt_enable;
	logic [7:0]    rx_config;
	logic          aw_full;
	logic          w_full;
	logic [7:0]    aw_addr;
	logic [31:0]   w_data;
	logic [3:0]    w_strb;
	lrf_rx_state_t rx_state;
	lrf_rx_state_t next_rx_state;
	logic [7:0]    hdr0;
	logic [7:0]    hdr1;
	logic [7:0]    air_len;
	logic [7:0]    cnt;
	logic [7:0]    next_cnt;
	logic [TS_W-1:0] ts_hold;
	lrf_rx_meta_t  meta;
	logic [7:0]    out_byte;
	logic          out_push;
	logic          out_last;
	logic          in_take;
	logic [31:0]   rx_evt;
	logic [31:0]   next_flags;

	// register decode
	wire aw_take   = s_axi_awvalid && s_axi_awready;
	wire w_take    = s_axi_wvalid && s_axi_wready;
	wire do_write  = aw_full && w_full && !s_axi_bvalid;
	wire wr_flags  = do_write && aw_addr == REG_EVT_FLAGS;
	wire wr_enable = do_write && aw_addr == REG_EVT_ENABLE;
	wire wr_config = do_write && aw_addr == REG_RX_CONFIG;
	wire wr_known  = wr_flags || wr_enable || wr_config || aw_addr == REG_EVT_LINES;
	wire ar_take   = s_axi_arvalid && s_axi_arready;
	wire rd_known  = s_axi_araddr == REG_EVT_FLAGS || s_axi_araddr == REG_EVT_ENABLE
		|| s_axi_araddr == REG_RX_CONFIG || s_axi_araddr == REG_EVT_LINES;
	wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	wire [31:0] rd_word = (s_axi_araddr == REG_EVT_FLAGS)  ? evt_flags :
		(s_axi_araddr == REG_EVT_ENABLE) ? evt_enable :
		(s_axi_araddr == REG_RX_CONFIG)  ? {24'h000000, rx_config} :
		(s_axi_araddr == REG_EVT_LINES)  ? evt_lines : 32'h0000_0000;

	// write address and data are held separately, so either may come first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_full <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'b00};
			end else if (do_write) begin
				aw_full <= 1'b0;
			end
			if (w_take) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (do_write) begin
				w_full <= 1'b0;
			end
			s_axi_awready <= !(aw_full || aw_take) || do_write;
			s_axi_wready <= !(w_full || w_take) || do_write;
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read answers one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !ar_take;
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// configuration registers, byte lanes honoured
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt_enable <= EVT_ENABLE_RST;
			rx_config <= RX_CONFIG_RST;
		end else begin
			if (wr_enable)
				evt_enable <= (evt_enable & ~wmask) | (w_data & wmask);
			if (wr_config && w_strb[0])
				rx_config <= w_data[7:0];
		end
	end

	// configuration field views
	wire [1:0] length_field_size      = rx_config[CFG_LEN_SZ_LSB +: 2];
	wire       keep_length_byte       = rx_config[CFG_KEEP_LEN];
	wire       keep_crc               = rx_config[CFG_KEEP_CRC];
	wire       append_signal_strength = rx_config[CFG_APPEND_RSSI];
	wire       append_status          = rx_config[CFG_APPEND_STAT];
	wire       append_timestamp       = rx_config[CFG_APPEND_TS];

	// entry length: header kept plus payload plus every appended field
	wire [7:0] hdr_bytes  = keep_length_byte ? 8'd2 : 8'd1;
	wire [7:0] extra      = (keep_crc ? CRC_BYTES : 8'd0)
		+ (append_signal_strength ? 8'd1 : 8'd0)
		+ (append_status ? 8'd1 : 8'd0)
		+ (append_timestamp ? TS_BYTES : 8'd0);
	wire [7:0] len_bytes  = (length_field_size == 2'd0) ? 8'd0 :
		(length_field_size == 2'd1) ? 8'd1 : 8'd2;
	wire [7:0] body_len   = hdr_bytes + air_len + extra;
	wire [7:0] need_space = body_len + len_bytes;
	wire [7:0] byte1_len  = {2'b00, rx_in_data[5:0]};
	wire       too_long   = byte1_len > MAX_PAYLOAD;

	// status byte in the receive_status_format
	wire [5:0] stat_chan   = (meta.channel > LAST_CHANNEL) ? BAD_CHANNEL : meta.channel;
	wire [7:0] status_byte = {!meta.crc_ok, meta.ignore, stat_chan};
	wire       can_emit    = !rx_out_valid || rx_out_ready;
	// a byte is taken only while ready stands, so both sides agree on every transfer
	wire       in_ok       = rx_in_valid && rx_in_ready;
	// nothing follows the payload: the header or payload byte closes the entry
	wire       no_tail     = !keep_crc && !append_signal_strength && !append_status
		&& !append_timestamp;

	// receive entry sequencer
	always_comb begin
		next_rx_state = rx_state;
		next_cnt = cnt;
		out_byte = 8'h00;
		out_push = 1'b0;
		out_last = 1'b0;
		in_take = 1'b0;
		case (rx_state)
			RX_IDLE: begin
				in_take = in_ok;
				if (in_ok)
					next_rx_state = RX_HDR1;
			end
			RX_HDR1: begin
				in_take = in_ok;
				if (in_ok) begin
					next_cnt = 8'd0;
					if (too_long)
						next_rx_state = RX_DROP;
					else
						next_rx_state = (length_field_size == 2'd0) ? RX_H0 : RX_LEN;
				end
			end
			RX_LEN: begin
				if (cnt == 8'd0 && need_space > rxq_space) begin
					next_cnt = air_len + CRC_BYTES;
					next_rx_state = RX_DROP;
				end else if (can_emit) begin
					out_push = 1'b1;
					out_byte = (cnt == 8'd0) ? body_len : 8'h00; // high byte: entry < 256
					next_cnt = cnt + 8'd1;
					if (cnt + 8'd1 >= len_bytes) begin
						next_cnt = 8'd0;
						next_rx_state = RX_H0;
					end
				end
			end
			RX_H0: begin
				if (can_emit) begin
					out_push = 1'b1;
					out_byte = hdr0;
					next_rx_state = keep_length_byte ? RX_H1 : (air_len == 8'd0) ? RX_CRC : RX_PAY;
				end
			end
			RX_H1: begin
				if (can_emit) begin
					out_push = 1'b1;
					out_byte = hdr1;
					next_rx_state = (air_len == 8'd0) ? RX_CRC : RX_PAY;
				end
			end
			RX_PAY: begin
				if (in_ok) begin
					in_take = 1'b1;
					out_push = 1'b1;
					out_byte = rx_in_data;
					next_cnt = cnt + 8'd1;
					if (cnt + 8'd1 == air_len) begin
						next_cnt = 8'd0;
						next_rx_state = RX_CRC;
					end
				end
			end
			RX_CRC: begin
				if (in_ok) begin
					in_take = 1'b1;
					out_push = keep_crc;
					out_byte = rx_in_data;
					next_cnt = cnt + 8'd1;
					if (cnt + 8'd1 == CRC_BYTES) begin
						next_cnt = 8'd0;
						next_rx_state = RX_RSSI;
					end
				end
			end
			RX_RSSI: begin
				if (!append_signal_strength) begin
					next_rx_state = RX_STAT;
				end else if (can_emit) begin
					out_push = 1'b1;
					out_byte = meta.rssi;
					next_rx_state = RX_STAT;
				end
			end
			RX_STAT: begin
				if (!append_status) begin
					next_rx_state = RX_TS;
				end else if (can_emit) begin
					out_push = 1'b1;
					out_byte = status_byte;
					next_rx_state = RX_TS;
				end
			end
			RX_TS: begin
				if (!append_timestamp) begin
					next_rx_state = RX_IDLE;
				end else if (can_emit) begin
					out_push = 1'b1;
					out_byte = ts_hold[cnt[1:0]*8 +: 8]; // low byte first
					next_cnt = cnt + 8'd1;
					if (cnt + 8'd1 == TS_BYTES)
						next_rx_state = RX_IDLE;
				end
			end
			RX_DROP: begin
				in_take = in_ok;
				if (in_ok) begin
					next_cnt = cnt - 8'd1;
					if (cnt <= 8'd1)
						next_rx_state = RX_IDLE;
				end
			end
			default: next_rx_state = RX_IDLE;
		endcase
		// the final byte of the entry closes it, whichever field that is
		if (out_push && next_rx_state == RX_IDLE)
			out_last = 1'b1;
		else if (out_push && rx_state == RX_STAT && !append_timestamp)
			out_last = 1'b1;
		else if (out_push && rx_state == RX_RSSI && !append_status && !append_timestamp)
			out_last = 1'b1;
		else if (out_push && rx_state == RX_CRC && next_rx_state == RX_RSSI
			&& !append_signal_strength && !append_status && !append_timestamp)
			out_last = 1'b1;
		else if (out_push && no_tail && next_rx_state == RX_CRC)
			out_last = 1'b1;
	end

	wire crc_last   = rx_state == RX_CRC && in_take && cnt + 8'd1 == CRC_BYTES;
	wire dropped    = rx_state == RX_LEN && cnt == 8'd0 && need_space > rxq_space;
	wire entry_done = out_push && out_last;
	wire good       = rx_meta.crc_ok && !rx_meta.ignore;
	wire is_ctrl    = hdr0[1:0] == LLID_CTRL;

	// every received packet that is not dropped lands in the receive queue as one entry
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_state <= RX_IDLE;
			cnt <= 8'd0;
			hdr0 <= 8'h00;
			hdr1 <= 8'h00;
			air_len <= 8'h00;
			ts_hold <= '0;
			meta <= '0;
			rx_out_valid <= 1'b0;
			rx_out_data <= 8'h00;
			rx_out_last <= 1'b0;
			rx_in_ready <= 1'b0;
		end else begin
			rx_state <= next_rx_state;
			cnt <= (rx_state == RX_HDR1 && in_take && too_long) ? byte1_len + CRC_BYTES : next_cnt;
			if (rx_state == RX_IDLE && in_take)
				hdr0 <= rx_in_data;
			if (rx_state == RX_HDR1 && in_take) begin
				air_len <= byte1_len;
				hdr1 <= rx_in_data;
			end
			if (rx_start)
				ts_hold <= rx_timestamp;       // start of packet
			if (crc_last)
				meta <= rx_meta;
			if (out_push) begin
				rx_out_valid <= 1'b1;
				rx_out_data <= out_byte;
				rx_out_last <= out_last;
			end else if (rx_out_ready) begin
				rx_out_valid <= 1'b0;
			end
			rx_in_ready <= (next_rx_state == RX_IDLE || next_rx_state == RX_HDR1
				|| next_rx_state == RX_DROP || next_rx_state == RX_PAY
				|| next_rx_state == RX_CRC) && !(out_push || (rx_out_valid && !rx_out_ready));
		end
	end

	// event vector; receive crc, ignore, good, empty and control events classified when the last crc byte arrives
	always_comb begin
		rx_evt = 32'h0000_0000;
		rx_evt[EV_BAD_CRC]       = crc_last && !rx_meta.crc_ok;
		rx_evt[EV_RX_IGNORED]    = crc_last && rx_meta.crc_ok && rx_meta.ignore;
		rx_evt[EV_RX_OK]         = crc_last && good && air_len != 8'd0;
		rx_evt[EV_RX_EMPTY]      = crc_last && good && air_len == 8'd0;
		rx_evt[EV_RX_CTRL]       = crc_last && good && is_ctrl;
		rx_evt[EV_RX_CTRL_ACK]   = seq_evt.rx_ctrl_acked;
		rx_evt[EV_RX_BUF_FULL]   = dropped;
		rx_evt[EV_RX_ENTRY_DONE] = entry_done || seq_evt.rx_entry_done;
		rx_evt[EV_CMD_DONE]      = seq_evt.cmd_done;
		rx_evt[EV_LAST_CMD_DONE] = seq_evt.last_cmd_done;
		rx_evt[EV_TX_DONE]       = seq_evt.tx_done;
		rx_evt[EV_TX_ACK]        = seq_evt.tx_ack;
		rx_evt[EV_RESEND]        = seq_evt.resend_evt;
		rx_evt[EV_TX_CTRL]       = seq_evt.tx_ctrl;
		rx_evt[EV_TX_CTRL_ACK]   = seq_evt.tx_ctrl_ack;
		rx_evt[EV_TX_CTRL_ACK2]  = seq_evt.tx_ctrl_ack_ack;
		rx_evt[EV_TX_ENTRY_DONE] = seq_evt.tx_entry_done;
		rx_evt[EV_TX_BUF_SWAP]   = seq_evt.buf_swapped;
		rx_evt[EV_MODULES_OPEN]  = seq_evt.modules_opened_evt;
		rx_evt[EV_BOOT_DONE]     = seq_evt.boot_done;
		rx_evt[EV_INTERNAL_ERR]  = seq_evt.internal_error;
	end

	// sticky flags: a new event beats a write-one-to-clear in the same cycle
	assign next_flags = (evt_flags & ~(wr_flags ? (w_data & wmask) : 32'h0)) | rx_evt;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt_flags <= EVT_FLAGS_RST;
			evt_lines <= 32'h0000_0000;
		end else begin
			evt_flags <= next_flags;
			evt_lines <= next_flags & evt_enable;
		end
	end

	// transmit header builder
	wire [7:0] adv_len  = (tx_req.two_addr ? ADV_ADDR_TWO : ADV_ADDR_ONE) + tx_req.data_len;
	wire [7:0] conn_len = (tx_req.entry_len == 8'd0) ? 8'd0 : tx_req.entry_len - 8'd1;
	wire [15:0] conn_hdr = {conn_len, 3'b000, tx_req.md, tx_req.sn, tx_req.nesn,
		tx_req.first_byte[1:0]};
	wire [15:0] adv_hdr  = {adv_len, tx_req.rx_add, tx_req.tx_add, 2'b00, tx_req.adv_type};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_hdr <= '0;
			tx_hdr_valid <= 1'b0;
		end else begin
			tx_hdr_valid <= tx_req_valid;
			if (tx_req_valid) begin
				tx_hdr.header <= tx_req.connected ? conn_hdr : adv_hdr;
				tx_hdr.from_queue <= tx_req.connected;
				tx_hdr.fetch_buf <= !tx_req.connected && tx_req.data_len != 8'd0;
				tx_hdr.buf_len <= tx_req.connected ? conn_len : tx_req.data_len;
			end
		end
	end
endmodule

//--- lrf_framer_properties.sv
/* lrf_framer_properties: port checks on the framer.
   assumes binding to lrf_framer, one clock and its reset. */
`timescale 1ns/100ps
module lrf_framer_properties
	import lrf_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [31:0] evt_lines,
	input wire logic [7:0]  rx_out_data,
	input wire logic        rx_out_valid,
	input wire logic        rx_out_ready,
	input wire lrf_tx_req_t tx_req,
	input wire logic        tx_req_valid,
	input wire lrf_tx_hdr_t tx_hdr,
	input wire logic        tx_hdr_valid
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// request kinds, the header follows one cycle later
	sequence s_conn;
		tx_req_valid && tx_req.connected;
	endsequence
	sequence s_adv;
		tx_req_valid && !tx_req.connected;
	endsequence
	a_hdr_timing: assert property (tx_req_valid |=> tx_hdr_valid)
		else $error("header valid missing");
	a_hdr_cause: assert property (tx_hdr_valid |-> $past(tx_req_valid))
		else $error("header valid without request");
	a_conn_llid: assert property (s_conn |=> tx_hdr.header[1:0] == $past(tx_req.first_byte[1:0])
		&& tx_hdr.header[15:8] == $past(tx_req.entry_len) - 8'd1)
		else $error("connected llid or length wrong");
	a_conn_bits: assert property (s_conn |=> tx_hdr.header[7:2] ==
		{3'h0, $past(tx_req.md), $past(tx_req.sn), $past(tx_req.nesn)})
		else $error("connected header bits wrong");
	a_conn_queue: assert property (s_conn |=> tx_hdr.from_queue)
		else $error("connected data not from queue");
	a_adv_len: assert property (s_adv |=> tx_hdr.header[15:8] ==
		$past(tx_req.data_len) + ($past(tx_req.two_addr) ? 8'd12 : 8'd6))
		else $error("advertising length wrong");
	a_adv_skip: assert property (s_adv ##0 tx_req.data_len == 8'd0 |=> !tx_hdr.fetch_buf)
		else $error("empty buffer fetched");
	// with no write under way a set event line cannot drop
	a_flags_hold: assert property (s_axi_wready && !s_axi_wvalid
		|=> (evt_lines & $past(evt_lines)) == $past(evt_lines))
		else $error("event line dropped without a write");
	a_rx_hold: assert property (rx_out_valid && !rx_out_ready
		|=> rx_out_valid && $stable(rx_out_data))
		else $error("entry byte changed while stalled");
endmodule
bind lrf_framer lrf_framer_properties u_props (.*);

//--- lrf_pkg.sv
/*
 * lrf_pkg: shared constants and carrier types for the low-energy radio
 * buffer framer and its event flags.
 * Assumes a single 250 MHz clock domain and byte-wide modem streams.
 */
package lrf_pkg;
	// register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] REG_EVT_FLAGS  = 8'h00;
	localparam logic [7:0] REG_EVT_ENABLE = 8'h04;
	localparam logic [7:0] REG_RX_CONFIG  = 8'h08;
	localparam logic [7:0] REG_EVT_LINES  = 8'h0c;
	localparam logic [31:0] EVT_FLAGS_RST  = 32'h0000_0000;
	localparam logic [31:0] EVT_ENABLE_RST = 32'h0000_0000;
	localparam logic [7:0]  RX_CONFIG_RST  = 8'h00;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// receive entry config byte fields
	localparam int CFG_LEN_SZ_LSB   = 0;
	localparam int CFG_KEEP_LEN     = 3;
	localparam int CFG_KEEP_CRC     = 4;
	localparam int CFG_APPEND_RSSI  = 5;
	localparam int CFG_APPEND_STAT  = 6;
	localparam int CFG_APPEND_TS    = 7;

	// event numbers in the 32-bit event vector
	localparam int EV_CMD_DONE      = 0;
	localparam int EV_LAST_CMD_DONE = 1;
	localparam int EV_TX_DONE       = 4;
	localparam int EV_TX_ACK        = 5;
	localparam int EV_TX_CTRL       = 6;
	localparam int EV_TX_CTRL_ACK   = 7;
	localparam int EV_TX_CTRL_ACK2  = 8;
	localparam int EV_RESEND        = 9;
	localparam int EV_TX_ENTRY_DONE = 10;
	localparam int EV_TX_BUF_SWAP   = 11;
	localparam int EV_RX_OK         = 16;
	localparam int EV_BAD_CRC       = 17;
	localparam int EV_RX_IGNORED    = 18;
	localparam int EV_RX_EMPTY      = 19;
	localparam int EV_RX_CTRL       = 20;
	localparam int EV_RX_CTRL_ACK   = 21;
	localparam int EV_RX_BUF_FULL   = 22;
	localparam int EV_RX_ENTRY_DONE = 23;
	localparam int EV_MODULES_OPEN  = 29;
	localparam int EV_BOOT_DONE     = 30;
	localparam int EV_INTERNAL_ERR  = 31;

	// packet layout
	localparam logic [7:0] CRC_BYTES     = 8'd3;
	localparam logic [7:0] TS_BYTES      = 8'd4;
	localparam logic [7:0] MAX_PAYLOAD   = 8'd37;
	localparam logic [5:0] LAST_CHANNEL  = 6'd39;
	localparam logic [5:0] BAD_CHANNEL   = 6'h3f;
	localparam logic [1:0] LLID_CTRL     = 2'h3;
	localparam logic [7:0] ADV_ADDR_ONE  = 8'd6;
	localparam logic [7:0] ADV_ADDR_TWO  = 8'd12;

	// sequencer event pulses, one cycle each
	typedef struct packed {
		logic cmd_done;
		logic last_cmd_done;
		logic tx_done;
		logic tx_ack;
		logic tx_ctrl;
		logic tx_ctrl_ack;
		logic tx_ctrl_ack_ack;
		logic resend_evt;
		logic tx_entry_done;
		logic buf_swapped;
		logic rx_ctrl_acked;
		logic rx_entry_done;
		logic modules_opened_evt;
		logic boot_done;
		logic internal_error;
	} lrf_seq_evt_t;

	// status sampled with the last received CRC byte
	typedef struct packed {
		logic       crc_ok;
		logic       ignore;
		logic [7:0] rssi;
		logic [5:0] channel;
	} lrf_rx_meta_t;

	// transmit header request
	typedef struct packed {
		logic       connected;
		logic [7:0] entry_len;
		logic [7:0] first_byte;
		logic       nesn;
		logic       sn;
		logic       md;
		logic [3:0] adv_type;
		logic       two_addr;
		logic       tx_add;
		logic       rx_add;
		logic [7:0] data_len;
	} lrf_tx_req_t;

	typedef struct packed {
		logic [15:0] header;
		logic        from_queue;
		logic        fetch_buf;
		logic [7:0]  buf_len;
	} lrf_tx_hdr_t;

	typedef enum logic [3:0] {
		RX_IDLE  = 4'h0,
		RX_HDR1  = 4'h1,
		RX_LEN   = 4'h2,
		RX_H0    = 4'h3,
		RX_H1    = 4'h4,
		RX_PAY   = 4'h5,
		RX_CRC   = 4'h6,
		RX_RSSI  = 4'h7,
		RX_STAT  = 4'h8,
		RX_TS    = 4'h9,
		RX_DROP  = 4'ha
	} lrf_rx_state_t;
endpackage

//--- lrf_queue_model.sv
/* lrf_queue_model: receive queue that stores entry bytes.
   assumes one clock; space never runs short in these tests. */
`timescale 1ns/100ps
module lrf_queue_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [7:0] rx_out_data,
	input  wire logic       rx_out_valid,
	output logic            rx_out_ready,
	output logic [7:0]      rxq_space
);
	logic [7:0] got[$];
	// stall every other cycle so each byte must be held
	always @(posedge aclk) begin
		rx_out_ready <= aresetn & ~rx_out_ready;
		rxq_space <= 8'hff - 8'(got.size());
		if (aresetn && rx_out_valid && rx_out_ready) got.push_back(rx_out_data);
	end
endmodule

//--- test_lrf_framer.sv
/* test_lrf_framer: register, event, receive and transmit tests.
   assumes lrf_queue_model on the entry stream and the bound checker. */
`timescale 1ns/100ps
module test_lrf_framer;
	import lrf_pkg::*;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, rx_start = 0, rx_in_valid = 0, tx_req_valid = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_in_ready;
	logic rx_out_valid, rx_out_last, rx_out_ready, tx_hdr_valid;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, rx_in_data = 0, rxq_space, rx_out_data, n;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, evt_lines, rx_timestamp = 0, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [15:0] h;
	lrf_seq_evt_t seq_evt = '0;
	lrf_rx_meta_t rx_meta = '0;
	lrf_tx_req_t tx_req = '0;
	lrf_tx_hdr_t tx_hdr;
	logic [7:0] want[$], pk[7] = '{8'h03, 8'h42, 8'ha1, 8'ha2, 8'hc1, 8'hc2, 8'hc3};
	int errors = 0, n_compared = 0;
	int evn[15] = '{0, 1, 4, 5, 6, 7, 8, 9, 10, 11, 21, 23, 29, 30, 31};
	lrf_framer DUT (.*);
	lrf_queue_model P (.*);
	initial begin
		forever #2 aclk = ~aclk;
	end
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic close_out();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic tmo();
		errors++;
		close_out();
	endtask
	// bus master: hold each channel until its ready, bready until bvalid
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (int k = 0; k < 40; k++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) break;
			if (k == 39) tmo();
		end
		rsp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (int k = 0; k < 40; k++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) break;
			if (k == 39) tmo();
		end
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task automatic send(input logic [7:0] b);
		rx_in_data <= b;
		rx_in_valid <= 1;
		for (int k = 0; k < 40; k++) begin
			@(posedge aclk);
			if (rx_in_ready) break;
			if (k == 39) tmo();
		end
	endtask
	// one packet; channel 45 is out of range so status carries 3f
	task automatic rx_pkt(input logic [7:0] cfg, input logic ok);
		wr(REG_RX_CONFIG, {24'h0, cfg});
		wr(REG_EVT_FLAGS, 32'hffffffff);
		n = 8'(3 + cfg[3] + 3 * cfg[4] + cfg[5] + cfg[6] + 4 * cfg[7]);
		want = {};
		P.got = {};
		if (cfg[1:0] != 0) want.push_back(n);
		if (cfg[1]) want.push_back(8'h00);
		want.push_back(pk[0]);
		if (cfg[3]) want.push_back(pk[1]);
		want.push_back(pk[2]);
		want.push_back(pk[3]);
		if (cfg[4]) for (int i = 4; i < 7; i++) want.push_back(pk[i]);
		if (cfg[5]) want.push_back(8'h55);
		if (cfg[6]) want.push_back({~ok, 7'h3f});
		if (cfg[7]) for (int i = 1; i < 5; i++) want.push_back(8'(i));
		rx_meta <= '{crc_ok: ok, ignore: 1'b0, rssi: 8'h55, channel: 6'd45};
		rx_timestamp <= 32'h04030201;
		rx_start <= 1;
		@(posedge aclk);
		rx_start <= 0;
		for (int i = 0; i < 7; i++) send(pk[i]);
		rx_in_valid <= 0;
		for (int k = 0; k < 200 && P.got.size() < want.size(); k++) @(posedge aclk);
		chk("entry size", want.size(), P.got.size());
		foreach (want[i]) chk("entry", want[i], P.got[i]);
		rd_reg(REG_EVT_FLAGS);
		chk("rx events", ok ? 32'h00910000 : 32'h00820000, rd & 32'h00ff0000);
	endtask
	task automatic tx(input lrf_tx_req_t q);
		@(posedge aclk);
		tx_req <= q;
		tx_req_valid <= 1;
		@(posedge aclk);
		tx_req_valid <= 0;
		@(negedge aclk);
		h = q.connected ? {q.entry_len - 8'd1, 3'h0, q.md, q.sn, q.nesn, q.first_byte[1:0]}
			: {(q.two_addr ? 8'd12 : 8'd6) + q.data_len, q.rx_add, q.tx_add, 2'h0, q.adv_type};
		chk("tx valid", 1, tx_hdr_valid);
		chk("tx hdr", h, tx_hdr.header);
		chk("tx queue", q.connected, tx_hdr.from_queue);
		chk("tx len", q.connected ? q.entry_len - 8'd1 : q.data_len, tx_hdr.buf_len);
		if (!q.connected) chk("tx fetch", q.data_len != 0, tx_hdr.fetch_buf);
	endtask
	// reset, registers, every sequencer event, two packets, then headers
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		repeat (2) @(posedge aclk);
		for (int a = 0; a < 12; a += 4) begin
			rd_reg(8'(a));
			chk("reset", 0, rd);
		end
		rd_reg(8'h40);
		chk("rd resp", RESP_SLVERR, rsp);
		wr(8'h40, 1);
		chk("wr resp", RESP_SLVERR, rsp);
		wr(REG_EVT_ENABLE, 32'h0000ffff);
		for (int i = 0; i < 15; i++) begin
			@(posedge aclk);
			seq_evt <= lrf_seq_evt_t'(15'h4000 >> i);
			@(posedge aclk);
			seq_evt <= '0;
			rd_reg(REG_EVT_FLAGS);
			chk("flag", 32'h1 << evn[i], rd);
			chk("line", (32'h1 << evn[i]) & 32'hffff, evt_lines);
			wr(REG_EVT_FLAGS, 32'h1 << evn[i]);
			rd_reg(REG_EVT_FLAGS);
			chk("cleared", 0, rd);
		end
		rx_pkt(8'hfa, 1'b1);
		rx_pkt(8'h40, 1'b0);
		for (int i = 0; i < 32; i++)
			tx({i[4], 8'(i + 1), 8'(i * 37), 3'(i), 4'(i), 3'(i >> 1), 8'(i[3] ? 22 : 0)});
		close_out();
	end
endmodule
